// file: src/dmie_exec.sv
`timescale 1ns/1ps
`include "dmie_regs.svh"


module dmie_exec #(
  parameter logic [11:0] ACCUM_ADDR = `DMIE_ACCUM_ADDR,
  parameter int ACCESS_SPLIT = `DMIE_ACCESS_SPLIT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Instruction fetch
  input wire logic [15:0] fetch_word,
  input wire logic fetch_valid,
  output logic fetch_ack,
  // Data memory, one cycle read latency
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Core state
  output logic [7:0] accum,
  output logic [7:0] bank_select_register,
  output logic [1:0] phase,
  output logic move_pending
);
  import dmie_pkg::*;

  // The split is compared against an 8-bit file address, so one bank is the most it can mean
  if (ACCESS_SPLIT < 1 || ACCESS_SPLIT > 256) begin : g_split_check
    $error("ACCESS_SPLIT must lie in 1..256");
  end

  localparam logic [8:0] SPLIT9 = 9'(ACCESS_SPLIT);

  dmie_state_t st;
  dmie_op_t op;
  dmie_op_t next_op;
  logic [15:0] ir;
  logic cyc_ok;
  logic [7:0] move_data;

  function automatic dmie_op_t decode(input logic [15:0] w);
    dmie_op_t r;
    r = DMIE_OP_NONE;
    if (w[`DMIE_NIB_MSB:`DMIE_NIB_LSB] == `DMIE_OPC_FF_FIRST) begin
      r = DMIE_OP_FF_FIRST;
    end else if (w[`DMIE_BYTE_MSB:`DMIE_BYTE_LSB] == `DMIE_OPC_LOAD_BANK) begin
      r = DMIE_OP_LOAD_BANK;
    end else if (w[`DMIE_BYTE_MSB:`DMIE_BYTE_LSB] == `DMIE_OPC_LOAD_ACCUM) begin
      r = DMIE_OP_LOAD_ACCUM;
    end else if (w[`DMIE_BYTE_MSB:`DMIE_STORE_OPC_LSB] == `DMIE_OPC_STORE_ACCUM) begin
      r = DMIE_OP_STORE_ACCUM;
    end
    return r;
  endfunction

  // Low file addresses of the access bank sit in bank 0, the rest in the top bank
  function automatic logic [11:0] bank_addr(input logic acc, input logic [7:0] f,
                                            input logic [7:0] bank_sel);
    logic [11:0] r;
    if (acc) begin
      r = {bank_sel[`DMIE_BANK_BITS-1:0], f};
    end else if ({1'b0, f} < SPLIT9) begin
      r = {4'h0, f};
    end else begin
      r = {`DMIE_ACCESS_HIGH_BANK, f};
    end
    return r;
  endfunction

  // The accumulator is mapped into the data space; the move reaches it without a memory cycle
  function automatic logic is_accum(input logic [11:0] a);
    return a == ACCUM_ADDR;
  endfunction

  // A second word that lacks the 1111 prefix aborts the move rather than writing garbage
  always_comb begin
    next_op = DMIE_OP_NONE;
    if (fetch_valid) begin
      unique case (st)
        DMIE_ST_FF_DEST: begin
          if (fetch_word[`DMIE_NIB_MSB:`DMIE_NIB_LSB] == `DMIE_OPC_FF_SECOND) begin
            next_op = DMIE_OP_FF_SECOND;
          end
        end
        DMIE_ST_IDLE: begin
          next_op = decode(fetch_word);
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= `DMIE_PH_Q1;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Instruction register and cycle validity, captured at the end of Q1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir <= 16'h0000;
      op <= DMIE_OP_NONE;
      cyc_ok <= 1'b0;
    end else if (phase == `DMIE_PH_Q1) begin
      cyc_ok <= fetch_valid;
      op <= next_op;
      if (fetch_valid) begin
        ir <= fetch_word;
      end
    end
  end

  // A cycle without a fetched word is a stall: the move waits, which gives the third cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= DMIE_ST_IDLE;
      move_pending <= 1'b0;
    end else if (phase == `DMIE_PH_Q4 && cyc_ok) begin
      unique case (st)
        DMIE_ST_IDLE: begin
          if (op == DMIE_OP_FF_FIRST) begin
            st <= DMIE_ST_FF_DEST;
            move_pending <= 1'b1;
          end
        end
        DMIE_ST_FF_DEST: begin
          // Completed or aborted, the move frees the fetch path after this cycle
          st <= DMIE_ST_IDLE;
          move_pending <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ack <= 1'b0;
    end else begin
      fetch_ack <= (phase == `DMIE_PH_Q3) && cyc_ok;
    end
  end

  // Memory strobes: read during Q2, write during Q4
  // Protected destinations are not filtered: software keeps the move away from them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= 12'h000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      if (phase == `DMIE_PH_Q1 && next_op == DMIE_OP_FF_FIRST &&
          !is_accum(fetch_word[`DMIE_FULL_ADDR_MSB:0])) begin
        mem_rd <= 1'b1;
        mem_addr <= fetch_word[`DMIE_FULL_ADDR_MSB:0];
      end else if (phase == `DMIE_PH_Q3 && op == DMIE_OP_STORE_ACCUM) begin
        mem_wr <= 1'b1;
        mem_addr <= bank_addr(ir[`DMIE_ACCESS_BIT], ir[7:0], bank_select_register);
        mem_wdata <= accum;
      end else if (phase == `DMIE_PH_Q3 && op == DMIE_OP_FF_SECOND &&
                   !is_accum(ir[`DMIE_FULL_ADDR_MSB:0])) begin
        mem_wr <= 1'b1;
        mem_addr <= ir[`DMIE_FULL_ADDR_MSB:0];
        mem_wdata <= move_data;
      end
    end
  end

  // Source byte: the accumulator itself, or the memory answer returned in Q3
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      move_data <= 8'h00;
    end else if (phase == `DMIE_PH_Q3 && op == DMIE_OP_FF_FIRST) begin
      if (is_accum(ir[`DMIE_FULL_ADDR_MSB:0])) begin
        move_data <= accum;
      end else begin
        move_data <= mem_rdata;
      end
    end
  end

  // Accumulator written at the end of Q4; no status flag exists or changes here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accum <= `DMIE_ACCUM_RESET;
    end else if (phase == `DMIE_PH_Q4) begin
      if (op == DMIE_OP_LOAD_ACCUM) begin
        accum <= ir[7:0];
      end else if (op == DMIE_OP_FF_SECOND && is_accum(ir[`DMIE_FULL_ADDR_MSB:0])) begin
        accum <= move_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_select_register <= `DMIE_BANK_RESET;
    end else if (phase == `DMIE_PH_Q4 && op == DMIE_OP_LOAD_BANK) begin
      bank_select_register <= ir[7:0];
    end
  end

endmodule

// file: src/dmie_regs.svh
`ifndef DMIE_REGS_SVH
`define DMIE_REGS_SVH

// Opcode patterns on the upper bits of a program word
`define DMIE_OPC_FF_FIRST 4'hc
`define DMIE_OPC_FF_SECOND 4'hf
`define DMIE_OPC_LOAD_BANK 8'h01
`define DMIE_OPC_LOAD_ACCUM 8'h0e
`define DMIE_OPC_STORE_ACCUM 7'h37

// Field positions within a program word
`define DMIE_NIB_MSB 15
`define DMIE_NIB_LSB 12
`define DMIE_BYTE_MSB 15
`define DMIE_BYTE_LSB 8
`define DMIE_STORE_OPC_LSB 9
`define DMIE_ACCESS_BIT 8
`define DMIE_FULL_ADDR_MSB 11

// Phases within one instruction cycle (one clock each)
`define DMIE_PH_Q1 2'h0
`define DMIE_PH_Q2 2'h1
`define DMIE_PH_Q3 2'h2
`define DMIE_PH_Q4 2'h3

// Data space layout
`define DMIE_ACCUM_ADDR 12'hfe8
`define DMIE_ACCESS_SPLIT 128
`define DMIE_ACCESS_HIGH_BANK 4'hf
`define DMIE_BANK_BITS 4

// Reset values
`define DMIE_ACCUM_RESET 8'h00
`define DMIE_BANK_RESET 8'h00

`endif

// file: src/dmie_pkg.sv
package dmie_pkg;

  typedef enum logic [2:0] {
    DMIE_OP_NONE,
    DMIE_OP_FF_FIRST,
    DMIE_OP_FF_SECOND,
    DMIE_OP_LOAD_BANK,
    DMIE_OP_LOAD_ACCUM,
    DMIE_OP_STORE_ACCUM
  } dmie_op_t;

  typedef enum logic {
    DMIE_ST_IDLE,
    DMIE_ST_FF_DEST
  } dmie_state_t;

endpackage

// file: verif/dmie_mem_model.sv
`timescale 1ns/1ps
module dmie_mem_model (
  // Data memory side
  input wire logic clk,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [4096];
  initial mem_rdata = 8'h00;
  // Outside a read the data toggles, so a late sample never sees a stale byte
  always @(posedge clk) begin
    if (mem_wr) begin
      ram[mem_addr] <= mem_wdata;
    end
    mem_rdata <= mem_rd ? ram[mem_addr] : ~mem_rdata;
  end
endmodule

// file: verif/dmie_checker.sv
`timescale 1ns/1ps
module dmie_checker (
  input wire logic clk, rst_n, fetch_valid, fetch_ack, mem_rd, mem_wr, move_pending,
  input wire logic [15:0] fetch_word,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] mem_wdata, mem_rdata, accum, bank_select_register,
  input wire logic [1:0] phase
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [15:0] fw;
  logic tk;
  assign fw = fetch_word;
  assign tk = phase == 2'h0 && fetch_valid && !move_pending;
  a_ack_after_take: assert property (phase == 2'h0 && fetch_valid |-> ##3 fetch_ack) else $error("no ack");
  a_stall_no_ack: assert property (phase == 2'h0 && !fetch_valid |-> ##3 !fetch_ack) else $error("stall ack");
  a_read_in_q2: assert property (mem_rd |-> phase == 2'h1 && !move_pending) else $error("bad read");
  a_write_in_q4: assert property (mem_wr |-> phase == 2'h3) else $error("bad write");
  a_accum_load: assert property (tk && fw[15:8] == 8'h0e |-> ##4 accum == $past(fw[7:0], 4))
    else $error("accum load");
  a_bank_load: assert property (tk && fw[15:8] == 8'h01 |-> ##4 bank_select_register == $past(fw[7:0], 4))
    else $error("bank load");
  a_store_banked: assert property (tk && fw[15:8] == 8'h6f |-> ##3 mem_wr && mem_wdata == accum
    && mem_addr == {bank_select_register[3:0], $past(fw[7:0], 3)}) else $error("store");
  a_move_source: assert property (tk && fw[15:12] == 4'hc && fw[11:0] != 12'hfe8
    |-> ##1 mem_rd && mem_addr == $past(fw[11:0])) else $error("move read");
  a_move_pends: assert property (tk && fw[15:12] == 4'hc |-> ##4 move_pending) else $error("no pending");
  c_move: cover property (tk && fw[15:12] == 4'hc);
  c_move_write: cover property (mem_wr && move_pending);
  c_move_stall: cover property (phase == 2'h0 && !fetch_valid && move_pending);
endmodule
bind dmie_exec dmie_checker chk (.*);

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, fetch_valid = 1'b0, fetch_ack, mem_rd, mem_wr, move_pending;
  logic [15:0] fetch_word = 16'h0000;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, accum, bank_select_register;
  logic [1:0] phase;
  int err_total = 0;
  int cmp_count = 0;
  dmie_exec uut (.*);
  dmie_mem_model mem (.*);
  always #12.5 clk = ~clk;
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One instruction cycle per call keeps the bench locked to the phase count
  task automatic op(input logic [15:0] w, input logic v = 1'b1);
    fetch_word = w;
    fetch_valid = v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic t_literal();
    op(16'h0e5a);
    op(16'h0105);
    chk("accum", accum, 12'h05a);
    chk("bank", bank_select_register, 12'h005);
    $display("literal test done");
  endtask
  task automatic t_store();
    op(16'h6f20);
    op(16'h6e21);
    op(16'h6e90);
    chk("banked", mem.ram[12'h520], 12'h05a);
    chk("access low", mem.ram[12'h021], 12'h05a);
    chk("access high", mem.ram[12'hf90], 12'h05a);
    chk("accum kept", accum, 12'h05a);
    $display("store test done");
  endtask
  task automatic t_move();
    mem.ram[12'hfff] = 8'h33;
    mem.ram[12'h000] = 8'h11;
    op(16'hcfff);
    op(16'hf000);
    chk("move dest", mem.ram[12'h000], 12'h033);
    chk("move src", mem.ram[12'hfff], 12'h033);
    mem.ram[12'h123] = 8'hc4;
    op(16'hc123);
    // A stalled word that would abort the pending move if wrongly taken
    op(16'h6e55, 1'b0);
    chk("pending", move_pending, 12'h001);
    op(16'hffe8);
    chk("dest accum", accum, 12'h0c4);
    op(16'hcfe8);
    op(16'hf7ab);
    chk("src accum", mem.ram[12'h7ab], 12'h0c4);
    $display("move test done");
  endtask
  task automatic t_abort();
    mem.ram[12'h045] = 8'h99;
    mem.ram[12'h3cc] = 8'h5e;
    op(16'hc045);
    op(16'h0e77);
    chk("abort accum", accum, 12'h0c4);
    chk("abort pending", move_pending, 12'h000);
    op(16'hf3cc);
    chk("lone second", mem.ram[12'h3cc], 12'h05e);
    $display("abort test done");
  endtask
  // Reset in mid-move must drop the pending move, or a later lone second word would write
  task automatic t_reset();
    op(16'hc045);
    rst_n = 1'b0;
    #1;
    chk("reset pending", move_pending, 12'h000);
    chk("reset accum", accum, 12'h000);
    chk("reset bank", bank_select_register, 12'h000);
    @(posedge clk);
    #1 rst_n = 1'b1;
    op(16'hf3cc);
    chk("reset cancels move", mem.ram[12'h3cc], 12'h05e);
    op(16'h0e3c);
    chk("accum after reset", accum, 12'h03c);
    $display("reset test done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    t_literal();
    t_store();
    t_move();
    t_abort();
    t_reset();
    tally_and_finish();
  end
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end
endmodule
